// *** verilog/egf_defines.svh ***
// offsets, reset values and timing counts of the gearing follower
`ifndef EGF_DEFINES_SVH
`define EGF_DEFINES_SVH
`define EGF_OFS_DECEL 16'h0172
`define EGF_OFS_DEN 16'h0176
`define EGF_OFS_MODE 16'h0178
`define EGF_OFS_NUM 16'h017A
`define EGF_OFS_ACCEL 16'h016E
`define EGF_OFS_STATUS 16'h017C
`define EGF_OFS_POS 16'h017E
`define EGF_RST_DEN 16'h0001
`define EGF_RST_MODE 16'h0000
`define EGF_RST_NUM 16'h0001
`define EGF_RST_ACCEL 64'h0000_0000_0001_0000
`define EGF_RST_DECEL 64'h0000_0000_0001_0000
`define EGF_MODE_MAX 16'h0001
`define EGF_OPMODE_POS 2'h2
`define EGF_CMDSRC_GEAR 2'h2
`define EGF_WIN_LOG2 8
`define EGF_FRAC 32
`endif

// *** verilog/egf_pkg.sv ***
// types shared by the gearing follower
`default_nettype none
package egf_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_SYNC = 2'b10,
    ST_STOP = 2'b11
  } egf_state_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [63:0] wdata;
  } egf_reg_req_s;
  typedef struct packed {
    logic start;
    logic stop;
  } egf_cmd_s;
  typedef struct packed {
    logic step;
    logic dir;
  } egf_pulse_s;
endpackage
`default_nettype wire

// *** verilog/egf_follower.sv ***
// electronic gearing follower: slave position from scaled master pulses
//
// Function
// - denominator 16-bit unsigned, 1..65535, default 1
// - slave velocity is master times numerator/denominator
// - mode selector 16-bit, 0 or 1, default 0
// - mode latched when gearing starts
// - mode 0 ramps up, synchronised on reaching velocity
// - mode 1 synchronised at once on start
// - ramp obeys accel limit, discards master counts
// - synchronised slave follows every master count
// - deceleration limited by 64-bit decel limit in ramp and stop, not while synchronised
// - velocity ceiling never clamps slave velocity
// - slave position drives position loop command
// - pulses before start never move slave
// - numerator signed 16-bit, default 1
// - start begins procedure, stop ends it
// - acceleration limited by accel limit register during the ramp, not while synchronised
`include "egf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module egf_follower (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // parameter access port
  input wire egf_pkg::egf_reg_req_s reg_req,
  output logic [63:0] reg_rdata,
  // drive commands and selectors
  input wire egf_pkg::egf_cmd_s cmd,
  input wire logic [1:0] operating_mode_selector,
  input wire logic [1:0] command_source_selector,
  // master pulse pins
  input wire egf_pkg::egf_pulse_s master_pins,
  // position loop side
  output logic [31:0] slave_pos_cmd,
  output logic synced,
  output logic gearing_active
);
  egf_pkg::egf_state_e state_q;
  logic [63:0] accel_q, decel_q, vel_q, tgt_vel_q, pos_q;
  logic [15:0] den_q, mode_q, mode_lat_q;
  logic signed [15:0] num_q;
  logic [1:0] step_sync_q, dir_sync_q;
  logic step_prev_q;
  logic signed [31:0] rem_q;
  logic signed [9:0] win_cnt_q;
  logic [`EGF_WIN_LOG2-1:0] win_tmr_q;
  logic pos_mode, go, halt, step_edge;
  logic signed [1:0] delta;
  logic signed [31:0] rem_sum, quot;
  logic signed [63:0] tgt_calc, diff, lim, vel_s;

  // true when the selectors put the drive in gearing position control
  assign pos_mode = (operating_mode_selector == `EGF_OPMODE_POS) &&
                    (command_source_selector == `EGF_CMDSRC_GEAR);
  assign go = cmd.start && pos_mode && (state_q == egf_pkg::ST_IDLE);
  assign halt = cmd.stop || !pos_mode;

  function automatic logic [63:0] mag(input logic [63:0] v);
    mag = v[63] ? (~v + 64'h0000_0000_0000_0001) : v;
  endfunction

  // parameter writes; out-of-range values are refused, old value kept
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      den_q <= `EGF_RST_DEN;
      mode_q <= `EGF_RST_MODE;
      num_q <= `EGF_RST_NUM;
      accel_q <= `EGF_RST_ACCEL;
      decel_q <= `EGF_RST_DECEL;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `EGF_OFS_DEN: if (reg_req.wdata[15:0] != 16'h0000) begin
          den_q <= reg_req.wdata[15:0];
        end
        `EGF_OFS_MODE: if (reg_req.wdata[15:0] <= `EGF_MODE_MAX) begin
          mode_q <= reg_req.wdata[15:0];
        end
        `EGF_OFS_NUM: num_q <= reg_req.wdata[15:0];
        `EGF_OFS_ACCEL: accel_q <= reg_req.wdata;
        `EGF_OFS_DECEL: decel_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // registered read data, unmapped offsets read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 64'h0000_0000_0000_0000;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `EGF_OFS_DEN: reg_rdata <= {48'h0000_0000_0000, den_q};
        `EGF_OFS_MODE: reg_rdata <= {48'h0000_0000_0000, mode_q};
        `EGF_OFS_NUM: reg_rdata <= {{48{num_q[15]}}, num_q};
        `EGF_OFS_ACCEL: reg_rdata <= accel_q;
        `EGF_OFS_DECEL: reg_rdata <= decel_q;
        `EGF_OFS_STATUS: reg_rdata <= {60'h0, mode_lat_q[0], state_q, synced};
        `EGF_OFS_POS: reg_rdata <= {32'h0000_0000, pos_q[63:32]};
        default: reg_rdata <= 64'h0000_0000_0000_0000;
      endcase
    end
  end

  // pin synchronisers; the edge detector looks only at the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_sync_q <= 2'b00;
      dir_sync_q <= 2'b00;
      step_prev_q <= 1'b0;
    end else begin
      step_sync_q <= {step_sync_q[0], master_pins.step};
      dir_sync_q <= {dir_sync_q[0], master_pins.dir};
      step_prev_q <= step_sync_q[1];
    end
  end

  assign step_edge = step_sync_q[1] && !step_prev_q;
  assign delta = !step_edge ? 2'sb00 : (dir_sync_q[1] ? -2'sd1 : 2'sd1);

  // ratio scaling with carried remainder, so rounding never drifts
  assign rem_sum = rem_q + 32'(delta * num_q);
  assign quot = rem_sum / $signed({16'h0000, den_q});

  // master speed: counts per window, scaled to q32 counts per cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_tmr_q <= '0;
      win_cnt_q <= 10'sd0;
      tgt_vel_q <= 64'h0000_0000_0000_0000;
    end else begin
      win_tmr_q <= win_tmr_q + 1'b1;
      if (win_tmr_q == '1) begin
        win_cnt_q <= 10'(delta);
        tgt_vel_q <= tgt_calc;
      end else begin
        win_cnt_q <= win_cnt_q + 10'(delta);
      end
    end
  end

  // scaled target velocity; the ceiling setting is not applied here
  assign tgt_calc = ((64'(win_cnt_q) * 64'(num_q)) <<<
                     (`EGF_FRAC - `EGF_WIN_LOG2)) /
                    $signed({48'h0000_0000_0000, den_q});

  // ramp step: accel limit while speeding up, decel limit slowing down
  always_comb begin
    vel_s = (state_q == egf_pkg::ST_STOP) ? 64'sd0 : tgt_vel_q;
    diff = vel_s - vel_q;
    lim = (mag(vel_s) > mag(vel_q)) ? accel_q : decel_q;
  end

  // procedure sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= egf_pkg::ST_IDLE;
      mode_lat_q <= `EGF_RST_MODE;
    end else begin
      case (state_q)
        egf_pkg::ST_IDLE: if (go) begin
          mode_lat_q <= mode_q;
          state_q <= (mode_q == `EGF_MODE_MAX) ? egf_pkg::ST_SYNC
                                               : egf_pkg::ST_RAMP;
        end
        egf_pkg::ST_RAMP: if (halt) begin
          state_q <= egf_pkg::ST_STOP;
        end else if (diff == 64'sd0 || (diff <= lim && diff >= -lim)) begin
          state_q <= egf_pkg::ST_SYNC;
        end
        egf_pkg::ST_SYNC: if (halt) begin
          state_q <= egf_pkg::ST_STOP;
        end
        egf_pkg::ST_STOP: if (vel_q == 64'h0000_0000_0000_0000) begin
          state_q <= egf_pkg::ST_IDLE;
        end
        default: state_q <= egf_pkg::ST_IDLE;
      endcase
    end
  end

  // velocity and position; counts are only used once synchronised
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vel_q <= 64'h0000_0000_0000_0000;
      pos_q <= 64'h0000_0000_0000_0000;
      rem_q <= 32'sd0;
    end else begin
      case (state_q)
        egf_pkg::ST_RAMP, egf_pkg::ST_STOP: begin
          rem_q <= 32'sd0;
          pos_q <= pos_q + vel_q;
          if (diff > lim) begin
            vel_q <= vel_q + lim;
          end else if (diff < -lim) begin
            vel_q <= vel_q - lim;
          end else begin
            vel_q <= vel_s;
          end
        end
        egf_pkg::ST_SYNC: begin
          // exact count following; limits would cost counts here
          // a stop hands the present speed over to the stop ramp
          if (halt) begin
            vel_q <= tgt_vel_q;
          end else begin
            pos_q <= pos_q + {quot, 32'h0000_0000};
            rem_q <= rem_sum - quot * $signed({16'h0000, den_q});
            vel_q <= tgt_vel_q;
          end
        end
        default: begin
          rem_q <= 32'sd0;
          vel_q <= 64'h0000_0000_0000_0000;
        end
      endcase
    end
  end

  // outputs to the position loop, all registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slave_pos_cmd <= 32'h0000_0000;
      synced <= 1'b0;
      gearing_active <= 1'b0;
    end else begin
      slave_pos_cmd <= pos_q[63:32];
      synced <= (state_q == egf_pkg::ST_SYNC);
      gearing_active <= (state_q != egf_pkg::ST_IDLE);
    end
  end

  // checks below run on the core clock and stay quiet during reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // accepted start events, split by the selected mode
  sequence s_go_mode0;
    go && mode_q == 16'h0000;
  endsequence
  sequence s_go_mode1;
    go && mode_q == 16'h0001;
  endsequence

  // stored parameters never leave their legal ranges
  a_den_range: assert property (den_q != 16'h0000)
    else $error("denominator became zero");
  a_mode_range: assert property (mode_q <= 16'h0001)
    else $error("mode selector out of range");
  // start in mode 0 enters the ramp with the mode latched
  a_mode0_ramp: assert property (
    s_go_mode0 |=> state_q == egf_pkg::ST_RAMP && mode_lat_q == 16'h0000)
    else $error("mode 0 start did not ramp");
  // start in mode 1 is synchronised at once, flag a cycle later
  a_mode1_sync: assert property (
    s_go_mode1 |=> state_q == egf_pkg::ST_SYNC ##1 synced)
    else $error("mode 1 start not synchronised");
  // the latch only moves on the edge that leaves idle
  a_mode_held: assert property (
    state_q != egf_pkg::ST_IDLE |=> $stable(mode_lat_q))
    else $error("latched mode changed mid procedure");
  // nothing moves the slave before a start command
  a_idle_still: assert property (
    state_q == egf_pkg::ST_IDLE |=> $stable(pos_q))
    else $error("slave moved before start");
  // master counts of the ramp interval are thrown away
  a_ramp_discard: assert property (
    state_q == egf_pkg::ST_RAMP |=> rem_q == 32'sd0)
    else $error("counts kept during ramp");
  // every synchronised count lands in the position, none dropped
  a_sync_follow: assert property (
    state_q == egf_pkg::ST_SYNC && !halt
    |=> pos_q[63:32] == $past(pos_q[63:32]) + $past(quot))
    else $error("synchronised count lost");
  // the carried remainder is always a proper fraction of one count
  a_rem_bound: assert property (mag(64'(rem_q)) < {48'h0, den_q})
    else $error("remainder not below denominator");
  // ramp and stop steps stay within the limit of the previous cycle
  a_ramp_step: assert property (
    (state_q == egf_pkg::ST_RAMP || state_q == egf_pkg::ST_STOP)
    |=> mag(vel_q - $past(vel_q)) <= mag($past(lim)))
    else $error("velocity step above limit");
  // a stop while synchronised leaves the sync state at once
  a_stop_ends: assert property (
    (state_q == egf_pkg::ST_SYNC) && cmd.stop
    |=> state_q == egf_pkg::ST_STOP)
    else $error("stop did not end gearing");
  // outside gearing position control a start is refused
  a_start_refused: assert property (
    state_q == egf_pkg::ST_IDLE && !pos_mode
    |=> state_q == egf_pkg::ST_IDLE)
    else $error("start taken outside position mode");
  // synced flag stays low for the whole ramp
  a_ramp_unsynced: assert property (
    state_q == egf_pkg::ST_RAMP |=> !synced)
    else $error("synced during ramp");
  // position command follows the internal position one cycle later
  a_pos_out: assert property (
    1'b1 |=> slave_pos_cmd == $past(pos_q[63:32]))
    else $error("position command lags wrongly");
endmodule // egf_follower
`default_nettype wire

// *** tb/egf_master_src.sv ***
// model of the external master pulse source
`timescale 1ns/1ps
`default_nettype none
module egf_master_src (
  // clock
  input wire logic core_clk,
  // master pulse pins
  output var egf_pkg::egf_pulse_s pins
);
  // pins idle low until the bench asks for pulses
  initial begin
    pins = '0;
  end
  // 3 cycles per half step so the two-stage sync never misses one
  task automatic send(input int n, input logic neg);
    @(posedge core_clk);
    #1 pins.dir = neg; // dir 1 counts negative
    repeat (n) begin
      repeat (3) @(posedge core_clk);
      #1 pins.step = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 pins.step = 1'b0;
    end
  endtask
endmodule // egf_master_src
`default_nettype wire

// *** tb/electronic_gearing_follower_tb.sv ***
// self-checking bench for the gearing follower
`include "egf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module electronic_gearing_follower_tb;
  logic core_clk;
  logic arst_n;
  egf_pkg::egf_reg_req_s rq;
  egf_pkg::egf_cmd_s cmd;
  egf_pkg::egf_pulse_s pins;
  logic [1:0] opm;
  logic [1:0] csrc;
  logic [63:0] rdata;
  logic [63:0] v;
  logic [31:0] pos;
  logic [31:0] p0;
  logic synced;
  logic active;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int i;
  logic [15:0] ofs [6] = '{`EGF_OFS_DEN, `EGF_OFS_MODE, `EGF_OFS_NUM,
    `EGF_OFS_ACCEL, `EGF_OFS_DECEL, 16'h0100};
  logic [63:0] rv [6] = '{64'h1, 64'h0, 64'h1, `EGF_RST_ACCEL,
    `EGF_RST_DECEL, 64'h0};

  // both drive selectors stay under bench control
  egf_follower uut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .reg_req(rq),
    .reg_rdata(rdata),
    .cmd(cmd),
    .operating_mode_selector(opm),
    .command_source_selector(csrc),
    .master_pins(pins),
    .slave_pos_cmd(pos),
    .synced(synced),
    .gearing_active(active)
  );
  egf_master_src src (
    .core_clk(core_clk),
    .pins(pins)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, well above the roughly 4.6k cycles of the run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [15:0] a, output logic [63:0] d);
    @(posedge core_clk);
    #1 rq.rd = 1'b1;
    rq.addr = a;
    @(posedge core_clk);
    #1 rq.rd = 1'b0;
    d = rdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    @(posedge core_clk);
    #1 rq.wr = 1'b1;
    rq.addr = a;
    rq.wdata = d;
    @(posedge core_clk);
    #1 rq.wr = 1'b0;
  endtask
  // one-cycle start (s=1) or stop (s=0) pulse
  task automatic go(input logic s);
    @(posedge core_clk);
    #1 cmd.start = s;
    cmd.stop = ~s;
    @(posedge core_clk);
    #1 cmd = '0;
  endtask
  // stop, then wait a bounded time for the ramp down to finish
  task automatic halt();
    go(1'b0);
    settle(2);
    chk(64'(synced), 64'h0);
    for (i = 0; i < 3000 && active !== 1'b0; i++) settle(1);
    chk(64'(active), 64'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    arst_n = 1'b0;
    rq = '0;
    cmd = '0;
    opm = 2'h2;
    csrc = 2'h2;
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(ofs[i], v);
      chk(v, rv[i]);
    end
    // out of range writes are dropped, the top denominator is kept
    wr(`EGF_OFS_DEN, 64'h0);
    wr(`EGF_OFS_MODE, 64'h2);
    rd(`EGF_OFS_DEN, v);
    chk(v, 64'h1);
    rd(`EGF_OFS_MODE, v);
    chk(v, 64'h0);
    wr(`EGF_OFS_DEN, 64'hFFFF);
    rd(`EGF_OFS_DEN, v);
    chk(v, 64'hFFFF);
    wr(`EGF_OFS_DECEL, 64'h0000_0000_0100_0000);
    rd(`EGF_OFS_DECEL, v);
    chk(v, 64'h0000_0000_0100_0000);
    // numerator is signed and reads back sign extended
    wr(`EGF_OFS_NUM, 64'hFFFF);
    rd(`EGF_OFS_NUM, v);
    chk(v, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(`EGF_OFS_NUM, 64'h1);
    rd(`EGF_OFS_NUM, v);
    chk(v, 64'h1);
    wr(`EGF_OFS_ACCEL, 64'h0000_0000_0100_0000);
    wr(`EGF_OFS_DEN, 64'h2); // half ratio stays under the ceiling
    wr(`EGF_OFS_MODE, 64'h1);
    src.send(5, 1'b0);
    settle(8);
    chk(64'(pos), 64'h0);
    // mode 1: locked at once, mode change mid-run has no effect
    go(1'b1);
    settle(2);
    chk(64'(synced), 64'h1);
    wr(`EGF_OFS_MODE, 64'h0);
    rd(`EGF_OFS_STATUS, v);
    chk(64'(v[3]), 64'h1);
    chk(64'(v[0]), 64'h1);
    src.send(10, 1'b0);
    src.send(4, 1'b1);
    settle(8);
    chk(64'(pos), 64'h3);
    rd(`EGF_OFS_POS, v);
    chk(v, 64'h3);
    halt();
    // mode 0: ramp first, lock later, then every count followed
    fork
      src.send(700, 1'b0);
      begin
        settle(300);
        go(1'b1);
        settle(2);
        chk(64'(synced), 64'h0);
        chk(64'(active), 64'h1);
        for (i = 0; i < 3000 && synced !== 1'b1; i++) settle(1);
        chk(64'(synced), 64'h1);
      end
    join
    // let the last count of the burst reach the output first
    settle(8);
    p0 = pos;
    src.send(20, 1'b0);
    settle(8);
    chk(64'(pos - p0), 64'ha);
    halt();
    // start with the wrong command source is ignored
    csrc = 2'h1;
    go(1'b1);
    settle(3);
    chk(64'(active), 64'h0);
    csrc = 2'h2;
    // start outside position mode is ignored
    opm = 2'h1;
    go(1'b1);
    settle(3);
    chk(64'(active), 64'h0);
    conclude();
  end
endmodule // electronic_gearing_follower_tb
`default_nettype wire
